// *** wisc_core.sv ***
// design: watch exception, interrupt entry vector and shadow register set control
`timescale 1ns/10ps
module wisc_core
  import wisc_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pipeline reports (same clock)
  input  wire wisc_pipe_s  pipe,
  // entry to the pipeline
  output wisc_entry_s      entry,
  // register set selectors
  output wisc_set_t        cur_set,
  output wisc_set_t        prev_set
);

  wisc_state_s s_q;
  wisc_state_s s_d;

  // ---------------------------------------------------------------
  // address match, interrupt mode and map decode
  // ---------------------------------------------------------------
  logic        addr_hit;
  logic        type_hit;
  logic        watch_hit;
  logic        exl_or_erl;
  logic        vect_irq;
  logic        eic_irq;
  logic [31:0] cmp_mask;
  wisc_set_t   map_set;
  logic [2:0]  map_idx;

  always_comb begin
    cmp_mask = {20'hfffff, ~s_q.watch_msk, 3'h0};
    addr_hit = ((pipe.ref_addr ^ {s_q.watch_lo[31:3], 3'h0}) & cmp_mask) == 32'h0;
    type_hit = (pipe.ref_fetch & s_q.watch_lo[WISC_WL_I_BIT])
             | (pipe.ref_load  & s_q.watch_lo[WISC_WL_R_BIT] & ~pipe.ref_cache_op)
             | (pipe.ref_store & s_q.watch_lo[WISC_WL_W_BIT] & ~pipe.ref_cache_op);
    watch_hit  = pipe.ref_valid & addr_hit & type_hit;
    exl_or_erl = s_q.exception_level_flag | s_q.error_level_flag;
    vect_irq   = s_q.iv & (s_q.vs != 5'h0) & ~s_q.external_ctrl_present & s_q.vectored_irq_supported;
    eic_irq    = s_q.iv & (s_q.vs != 5'h0) & s_q.external_ctrl_present;
    // priority level saturates at the eight map fields
    map_idx    = (pipe.irq_level > 6'd7) ? 3'd7 : pipe.irq_level[2:0];
    map_set    = s_q.srs_map[{map_idx, 2'b00} +: 4];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic        apb_wr;
  logic        apb_rd;
  logic        take_watch;
  logic        take_irq;
  logic        enter;
  logic        srs_frozen;
  logic [31:0] wv;

  always_comb begin
    s_d        = s_q;
    s_d.entry  = '0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    wv         = pwdata;
    apb_wr     = psel & ~penable & pwrite;
    apb_rd     = psel & ~penable & ~pwrite;
    take_watch = 1'b0;
    take_irq   = 1'b0;
    srs_frozen = 1'b1;
    enter      = 1'b0;

    // register access: answered in the access cycle, one wait-free phase
    if (psel & ~penable) begin
      s_d.pready = 1'b1;
    end
    if (apb_wr) begin
      if (paddr == WISC_OFS_WATCH_LO) begin
        s_d.watch_lo = wv;
      end else if (paddr == WISC_OFS_WATCH_HI) begin
        s_d.watch_msk = wv[WISC_WH_MSK_HI:WISC_WH_MSK_LO];
      end else if (paddr == WISC_OFS_CAUSE) begin
        s_d.iv = wv[WISC_CA_IV_BIT];
        s_d.wp = wv[WISC_CA_WP_BIT];
      end else if (paddr == WISC_OFS_STATUS) begin
        s_d.boot_vector_select = wv[WISC_ST_BEV_BIT];
        s_d.error_level_flag = wv[WISC_ST_ERL_BIT];
        s_d.exception_level_flag = wv[WISC_ST_EXL_BIT];
      end else if (paddr == WISC_OFS_SRS_CTL) begin
        s_d.exception_shadow_set = wv[WISC_SC_ESS_LO +: 4];
        s_d.previous_shadow_set = wv[WISC_SC_PSS_LO +: 4];
      end else if (paddr == WISC_OFS_SRS_MAP) begin
        s_d.srs_map = wv;
      end else if (paddr == WISC_OFS_INT_CTL) begin
        s_d.vs = wv[WISC_IC_VS_LO +: 5];
      end else if (paddr == WISC_OFS_CONFIG_THREE) begin
        s_d.external_ctrl_present = wv[WISC_C3_EXTERNAL_CTRL_PRESENT_BIT];
        s_d.vectored_irq_supported = wv[WISC_C3_VECTORED_IRQ_SUPPORTED_BIT];
      end else if (paddr != WISC_OFS_ENTRY) begin
        s_d.pslverr = 1'b1;
      end
    end
    if (apb_rd) begin
      s_d.prdata = WISC_ERR_DATA;
      if (paddr == WISC_OFS_WATCH_LO) begin
        s_d.prdata = s_q.watch_lo;
      end else if (paddr == WISC_OFS_WATCH_HI) begin
        s_d.prdata[WISC_WH_MSK_HI:WISC_WH_MSK_LO] = s_q.watch_msk;
      end else if (paddr == WISC_OFS_CAUSE) begin
        s_d.prdata[WISC_CA_IV_BIT] = s_q.iv;
        s_d.prdata[WISC_CA_WP_BIT] = s_q.wp;
        s_d.prdata[WISC_CA_IP_LO +: 8] = s_q.ip;
        s_d.prdata[WISC_CA_EC_LO +: 5] = s_q.code;
      end else if (paddr == WISC_OFS_STATUS) begin
        s_d.prdata[WISC_ST_BEV_BIT] = s_q.boot_vector_select;
        s_d.prdata[WISC_ST_ERL_BIT] = s_q.error_level_flag;
        s_d.prdata[WISC_ST_EXL_BIT] = s_q.exception_level_flag;
      end else if (paddr == WISC_OFS_SRS_CTL) begin
        s_d.prdata[WISC_SC_HSS_LO +: 4] = WISC_SETS_HIGH;
        s_d.prdata[WISC_SC_EIC_LO +: 4] = s_q.external_ctrl_shadow_set;
        s_d.prdata[WISC_SC_ESS_LO +: 4] = s_q.exception_shadow_set;
        s_d.prdata[WISC_SC_PSS_LO +: 4] = s_q.previous_shadow_set;
        s_d.prdata[WISC_SC_CSS_LO +: 4] = s_q.current_shadow_set;
      end else if (paddr == WISC_OFS_SRS_MAP) begin
        s_d.prdata = s_q.srs_map;
      end else if (paddr == WISC_OFS_INT_CTL) begin
        s_d.prdata[WISC_IC_VS_LO +: 5] = s_q.vs;
      end else if (paddr == WISC_OFS_CONFIG_THREE) begin
        s_d.prdata[WISC_C3_EXTERNAL_CTRL_PRESENT_BIT] = s_q.external_ctrl_present;
        s_d.prdata[WISC_C3_VECTORED_IRQ_SUPPORTED_BIT] = s_q.vectored_irq_supported;
      end else if (paddr == WISC_OFS_ENTRY) begin
        s_d.prdata = {8'h0, s_q.entry.is_watch, s_q.entry.code, 6'h0, s_q.entry.offset};
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    // watch detection; debug mode blocks everything
    if (!pipe.debug_mode) begin
      if (watch_hit && !exl_or_erl && !pipe.ref_other_exc) begin
        take_watch = 1'b1;
      end else if (watch_hit && exl_or_erl && pipe.ref_completes && !pipe.ref_other_exc) begin
        // defer, set only on clean completion
        s_d.wp = 1'b1;
      end
      if (s_q.wp && !exl_or_erl) begin
        take_watch = 1'b1;
      end
    end
    // debug leaves pending alone (only a cause register write above touches it)

    if (pipe.exc_valid && pipe.exc_kind == WISC_KIND_IRQ) begin
      take_irq   = ~take_watch;
    end
    enter = take_watch | take_irq | (pipe.exc_valid & ~take_irq);

    if (take_watch) begin
      s_d.code           = WISC_CODE_WATCH;
      s_d.entry.take     = 1'b1;
      s_d.entry.is_watch = 1'b1;
      s_d.entry.code     = WISC_CODE_WATCH;
      s_d.entry.offset   = WISC_VEC_GENERAL;
    end else if (take_irq) begin
      s_d.code         = WISC_CODE_INT;
      s_d.ip           = pipe.irq_pending;
      s_d.entry.take   = 1'b1;
      s_d.entry.code   = WISC_CODE_INT;
      s_d.entry.offset = s_q.iv ? WISC_VEC_IRQ : WISC_VEC_GENERAL;
    end

    s_d.external_ctrl_shadow_set = pipe.ext_set;

    if (enter) begin
      srs_frozen = (pipe.exc_valid && !take_watch &&
                    (pipe.exc_kind == WISC_KIND_ERL || pipe.exc_kind == WISC_KIND_DEBUG))
                 || s_q.boot_vector_select || s_q.exception_level_flag;
      if (!srs_frozen) begin
        s_d.previous_shadow_set = s_q.current_shadow_set;
        if (take_irq && vect_irq) begin
          s_d.current_shadow_set = map_set;
        end else if (take_irq && eic_irq) begin
          s_d.current_shadow_set = pipe.ext_set;
        end else begin
          s_d.current_shadow_set = s_q.exception_shadow_set;
        end
      end
      s_d.exception_level_flag = (pipe.exc_valid && !take_watch && pipe.exc_kind == WISC_KIND_ERL) ? s_q.exception_level_flag : 1'b1;
      if (pipe.exc_valid && !take_watch && pipe.exc_kind == WISC_KIND_ERL) begin
        s_d.error_level_flag = 1'b1;
      end
    end else if (pipe.exception_return_instr && !pipe.debug_return_instr) begin
      if (!s_q.error_level_flag && !s_q.boot_vector_select) begin
        s_d.current_shadow_set = s_q.previous_shadow_set;
      end
      if (s_q.error_level_flag) begin
        s_d.error_level_flag = 1'b0;
      end else begin
        s_d.exception_level_flag = 1'b0;
      end
    end

    if (s_d.current_shadow_set > WISC_SETS_HIGH) begin
      s_d.current_shadow_set = WISC_SETS_HIGH;
    end
    if (s_d.previous_shadow_set > WISC_SETS_HIGH) begin
      s_d.previous_shadow_set = WISC_SETS_HIGH;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q     <= '0;
      s_q.boot_vector_select <= WISC_STATUS_RST[WISC_ST_BEV_BIT];
      s_q.error_level_flag <= WISC_STATUS_RST[WISC_ST_ERL_BIT];
    end else begin
      s_q <= s_d;
    end
  end

  // registered outputs: apb response, entry and set selectors to the register file
  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;
  assign entry    = s_q.entry;
  assign cur_set  = s_q.current_shadow_set;
  assign prev_set = s_q.previous_shadow_set;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence clean_hit_s;
    watch_hit && !exl_or_erl && !pipe.debug_mode && !pipe.ref_other_exc;
  endsequence

  watch_takes_now_a: assert property (clean_hit_s |=> entry.take && entry.is_watch)
    else $error("clean watch match not taken");
  watch_defers_a: assert property (watch_hit && exl_or_erl && !pipe.debug_mode && pipe.ref_completes
                                   && !pipe.ref_other_exc |=> s_q.wp)
    else $error("deferred watch did not set pending");
  debug_keeps_wp_a: assert property (pipe.debug_mode && !(apb_wr && paddr == WISC_OFS_CAUSE)
                                     |=> s_q.wp == $past(s_q.wp) && !entry.is_watch)
    else $error("debug mode touched watch");
  pending_fires_a: assert property (s_q.wp && !exl_or_erl && !pipe.debug_mode |=> entry.is_watch)
    else $error("pending watch not raised");
  watch_vector_a: assert property (entry.is_watch |-> entry.offset == WISC_VEC_GENERAL
                                   && s_q.code == WISC_CODE_WATCH)
    else $error("watch entry vector wrong");
  irq_vector_a: assert property (take_irq |=> entry.take && entry.offset == ($past(s_q.iv) ? WISC_VEC_IRQ
                                 : WISC_VEC_GENERAL) && s_q.ip == $past(pipe.irq_pending))
    else $error("interrupt entry wrong");
  srs_frozen_a: assert property (enter && (s_q.boot_vector_select || s_q.exception_level_flag) && !apb_wr
                                 |=> $stable(s_q.current_shadow_set) && $stable(s_q.previous_shadow_set))
    else $error("shadow sets changed on frozen entry");
  srs_save_a: assert property (enter && !srs_frozen |=> s_q.previous_shadow_set == $past(s_q.current_shadow_set))
    else $error("previous set not saved");
  eic_set_a: assert property (enter && !srs_frozen && take_irq && eic_irq
                              |=> s_q.current_shadow_set == $past(pipe.ext_set))
    else $error("controller set not loaded");
  ret_restore_a: assert property (!enter && pipe.exception_return_instr && !pipe.debug_return_instr && !s_q.error_level_flag && !s_q.boot_vector_select
                                  |=> s_q.current_shadow_set == $past(s_q.previous_shadow_set))
    else $error("return did not restore set");

  // pending watch held by the exception level, then a plain return drops the level
  sequence held_pending_s;
    s_q.wp && s_q.exception_level_flag && !s_q.error_level_flag && !apb_wr && !pipe.exc_valid;
  endsequence

  sequence plain_return_s;
    pipe.exception_return_instr && !pipe.debug_return_instr;
  endsequence

  watch_source_a: assert property (entry.is_watch |-> $past(watch_hit || s_q.wp))
    else $error("watch entry without match or pending");
  wp_origin_a: assert property ($rose(s_q.wp) |-> $past(watch_hit && exl_or_erl)
                                || $past(apb_wr && paddr == WISC_OFS_CAUSE))
    else $error("pending rose without deferred match");
  other_exc_wp_a: assert property (!s_q.wp && pipe.ref_other_exc && !(apb_wr && paddr == WISC_OFS_CAUSE)
                                   |=> !s_q.wp)
    else $error("pending set by an instruction with another exception");
  cache_quiet_a: assert property (pipe.ref_cache_op && !pipe.ref_fetch |-> !watch_hit)
    else $error("cache op produced a data watch match");
  sc_fail_hit_a: assert property (pipe.ref_valid && pipe.ref_store && !pipe.ref_completes
                                  && !pipe.ref_cache_op && addr_hit && s_q.watch_lo[WISC_WL_W_BIT] |-> watch_hit)
    else $error("failed store missed the watch");
  return_fires_a: assert property (held_pending_s ##0 plain_return_s ##1 !pipe.debug_mode
                                   |=> entry.is_watch)
    else $error("pending watch not raised after return");
  hss_read_a: assert property (apb_rd && paddr == WISC_OFS_SRS_CTL
                               |=> prdata[WISC_SC_HSS_LO +: 4] == WISC_SETS_HIGH)
    else $error("highest set misreported");
  map_set_a: assert property (enter && !srs_frozen && take_irq && vect_irq
                              |=> s_q.current_shadow_set == $past(map_set))
    else $error("vectored set not loaded");
  ess_set_a: assert property (enter && !srs_frozen && !(take_irq && (vect_irq || eic_irq))
                              |=> s_q.current_shadow_set == $past(s_q.exception_shadow_set))
    else $error("exception set not loaded");
  debug_return_instr_keeps_a: assert property (pipe.debug_return_instr && !enter |=> $stable(s_q.current_shadow_set))
    else $error("debug return changed the current set");

endmodule

// *** wisc_core_bench.sv ***
// testbench: apb register tasks, pipeline reports and entry/shadow-set checks
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module wisc_core_bench
  import wisc_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam wisc_set_t   XS  = 4'h9;
  localparam logic [31:0] WA  = 32'h0000_1238;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  wisc_pipe_s  pipe;
  wisc_pipe_s  p;
  wisc_entry_s entry;
  wisc_entry_s last;
  wisc_set_t   cur_set;
  wisc_set_t   prev_set;
  int          failures;
  int          checks_done;
  int          takes;
  int          t0;
  int          i;

  wisc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pipe(pipe), .entry(entry), .cur_set(cur_set), .prev_set(prev_set));
  wisc_pipe_model #(.EXT_SET(XS)) i_pipe (.pclk(pclk), .pipe(pipe));

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // entry is a one-cycle pulse, so every pulse is counted here
  always @(posedge pclk) begin
    if (entry.take === 1'b1) begin
      takes++;
      last = entry;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    @(posedge pclk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd & m)
  endtask

  // settle covers the one-cycle entry latency plus a deferred watch after a return
  task automatic pulse(input wisc_pipe_s q);
    t0 = takes;
    i_pipe.send(q);
    repeat (3) @(posedge pclk);
  endtask

  task automatic chk_entry(input int n, input logic w, input logic [11:0] off, input logic [4:0] code);
    `CHK("take count", n, takes - t0)
    if (n > 0) begin
      `CHK("entry is_watch", w, last.is_watch)
      `CHK("entry offset", off, last.offset)
      `CHK("entry code", code, last.code)
    end
  endtask

  task automatic chk_sets(input wisc_set_t c, input wisc_set_t pv);
    `CHK("cur_set", c, cur_set)
    `CHK("prev_set", pv, prev_set)
  endtask

  function automatic wisc_pipe_s wref(input logic [31:0] a);
    wref = '0;
    wref.ref_valid = 1'b1;
    wref.ref_addr = a;
    wref.ref_store = 1'b1;
    wref.ref_completes = 1'b1;
  endfunction

  function automatic wisc_pipe_s wexc(input wisc_kind_e k);
    wexc = '0;
    wexc.exc_valid = 1'b1;
    wexc.exc_kind = k;
    wexc.irq_pending = 8'ha5;
    wexc.irq_level = 6'h02;
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    failures = 0;
    checks_done = 0;
    takes = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("status", WISC_OFS_STATUS, WISC_STATUS_RST, 32'hffff_ffff);
    rchk("srs_ctl", WISC_OFS_SRS_CTL, 32'(WISC_SETS_HIGH) << WISC_SC_HSS_LO, 32'h3c00_03cf);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", WISC_ERR_DATA, rd)
    apb(1'b1, 8'h40, 32'hffff_ffff);
    `CHK("unmapped write error", 1'b1, er)
    apb(1'b1, WISC_OFS_SRS_CTL, 32'h3 << WISC_SC_ESS_LO);
    pulse(wexc(WISC_KIND_OTHER));
    chk_sets(4'h0, 4'h0);
    $display("test reset done");
    apb(1'b1, WISC_OFS_STATUS, 32'h0);
    apb(1'b1, WISC_OFS_WATCH_LO, WA | 32'h1);
    apb(1'b1, WISC_OFS_WATCH_HI, 32'h0);
    pulse(wref(WA + 32'h8));
    chk_entry(0, 1'b0, 12'h0, 5'h0);
    pulse(wref(WA + 32'h4));
    chk_entry(1, 1'b1, WISC_VEC_GENERAL, WISC_CODE_WATCH);
    chk_sets(4'h3, 4'h0);
    rchk("exl", WISC_OFS_STATUS, 32'h1 << WISC_ST_EXL_BIT, 32'h1 << WISC_ST_EXL_BIT);
    p = wref(WA);
    p.debug_mode = 1'b1;
    pulse(p);
    chk_entry(0, 1'b0, 12'h0, 5'h0);
    rchk("wp debug", WISC_OFS_CAUSE, 32'h0, 32'h1 << WISC_CA_WP_BIT);
    p = wref(WA);
    p.ref_cache_op = 1'b1;
    pulse(p);
    rchk("wp cache", WISC_OFS_CAUSE, 32'h0, 32'h1 << WISC_CA_WP_BIT);
    p = wref(WA);
    p.ref_other_exc = 1'b1;
    p.ref_completes = 1'b0;
    pulse(p);
    rchk("wp other", WISC_OFS_CAUSE, 32'h0, 32'h1 << WISC_CA_WP_BIT);
    pulse(wref(WA));
    chk_entry(0, 1'b0, 12'h0, 5'h0);
    chk_sets(4'h3, 4'h0);
    rchk("wp set", WISC_OFS_CAUSE, 32'h1 << WISC_CA_WP_BIT, 32'h1 << WISC_CA_WP_BIT);
    p = '0;
    p.exception_return_instr = 1'b1;
    pulse(p);
    chk_entry(1, 1'b1, WISC_VEC_GENERAL, WISC_CODE_WATCH);
    chk_sets(4'h3, 4'h0);
    apb(1'b1, WISC_OFS_CAUSE, 32'h0);
    pulse(p);
    chk_entry(0, 1'b0, 12'h0, 5'h0);
    chk_sets(4'h0, 4'h0);
    $display("test watch done");
    pulse(wexc(WISC_KIND_OTHER));
    chk_sets(4'h3, 4'h0);
    // software switches set through a return
    apb(1'b1, WISC_OFS_SRS_CTL, (32'h6 << WISC_SC_PSS_LO) | (32'h3 << WISC_SC_ESS_LO));
    pulse(p);
    chk_sets(4'h6, 4'h6);
    pulse(wexc(WISC_KIND_IRQ));
    chk_entry(1, 1'b0, WISC_VEC_GENERAL, WISC_CODE_INT);
    chk_sets(4'h3, 4'h6);
    rchk("pending irqs", WISC_OFS_CAUSE, 32'ha5 << WISC_CA_IP_LO, 32'hff << WISC_CA_IP_LO);
    pulse(p);
    // vectored, external controller, then non-vectored with vector select set
    for (i = 0; i < 3; i++) begin
      apb(1'b1, WISC_OFS_CAUSE, 32'h1 << WISC_CA_IV_BIT);
      apb(1'b1, WISC_OFS_INT_CTL, (i == 2) ? 32'h0 : 32'h1 << WISC_IC_VS_LO);
      apb(1'b1, WISC_OFS_CONFIG_THREE, (i == 1) ? 32'h1 << WISC_C3_EXTERNAL_CTRL_PRESENT_BIT : 32'h1 << WISC_C3_VECTORED_IRQ_SUPPORTED_BIT);
      apb(1'b1, WISC_OFS_SRS_MAP, 32'h5 << 8);
      pulse(wexc(WISC_KIND_IRQ));
      chk_entry(1, 1'b0, WISC_VEC_IRQ, WISC_CODE_INT);
      chk_sets((i == 0) ? 4'h5 : (i == 1) ? XS : 4'h3, 4'h6);
      pulse(p);
      chk_sets(4'h6, 4'h6);
    end
    $display("test interrupt done");
    pulse(wexc(WISC_KIND_ERL));
    chk_sets(4'h6, 4'h6);
    apb(1'b1, WISC_OFS_STATUS, 32'h0);
    pulse(wexc(WISC_KIND_DEBUG));
    chk_sets(4'h6, 4'h6);
    // debug entry leaves the exception level set; clear it so the next entry is not frozen
    apb(1'b1, WISC_OFS_STATUS, 32'h0);
    pulse(wexc(WISC_KIND_OTHER));
    chk_sets(4'h3, 4'h6);
    p = '0;
    p.debug_return_instr = 1'b1;
    pulse(p);
    chk_sets(4'h3, 4'h6);
    // return at error level restores nothing and only drops the level; the next one restores
    apb(1'b1, WISC_OFS_STATUS, 32'h1 << WISC_ST_ERL_BIT);
    p = '0;
    p.exception_return_instr = 1'b1;
    pulse(p);
    chk_sets(4'h3, 4'h6);
    rchk("erl cleared", WISC_OFS_STATUS, 32'h0, 32'h7);
    pulse(p);
    chk_sets(4'h6, 4'h6);
    $display("test no update done");
    wrap_up();
  end
endmodule

// *** wisc_pipe_model.sv ***
// partner model: pipeline reports and the external interrupt controller's set number
`timescale 1ns/10ps
module wisc_pipe_model
  import wisc_pkg::*;
#(
  parameter wisc_set_t EXT_SET = 4'h9
)
(
  // clock
  input  wire logic pclk,
  // report to the unit
  output wisc_pipe_s pipe
);
  // ---------------------------------------------------------------
  // one-cycle reports
  // ---------------------------------------------------------------
  initial begin
    pipe = '0;
  end

  // called just after a rising edge; the report stands for one cycle
  task automatic send(input wisc_pipe_s p);
    wisc_pipe_s q;
    wisc_pipe_s r;
    q = p;
    q.ext_set = EXT_SET;
    pipe <= q;
    @(posedge pclk);
    // released address lines carry the inverse so a stale match cannot pass
    r = '0;
    r.ref_addr = ~p.ref_addr;
    r.ext_set = ~EXT_SET;
    pipe <= r;
  endtask
endmodule

// *** wisc_pkg.sv ***
// package: constants, register map and carrier types for the watch/interrupt/shadow-set exception unit
package wisc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets (apb, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] WISC_OFS_WATCH_LO  = 8'h00;
  localparam logic [7:0] WISC_OFS_WATCH_HI  = 8'h04;
  localparam logic [7:0] WISC_OFS_CAUSE     = 8'h08;
  localparam logic [7:0] WISC_OFS_STATUS    = 8'h0c;
  localparam logic [7:0] WISC_OFS_SRS_CTL   = 8'h10;
  localparam logic [7:0] WISC_OFS_SRS_MAP   = 8'h14;
  localparam logic [7:0] WISC_OFS_INT_CTL   = 8'h18;
  localparam logic [7:0] WISC_OFS_CONFIG_THREE   = 8'h1c;
  localparam logic [7:0] WISC_OFS_ENTRY     = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  // watch low: [31:3] address, [2] fetch, [1] load, [0] store
  localparam int WISC_WL_I_BIT  = 2;
  localparam int WISC_WL_R_BIT  = 1;
  localparam int WISC_WL_W_BIT  = 0;
  // watch high: [11:3] address don't-care mask
  localparam int WISC_WH_MSK_LO = 3;
  localparam int WISC_WH_MSK_HI = 11;
  // cause: [23] vector select, [22] watch pending, [15:8] pending irqs, [6:2] code
  localparam int WISC_CA_IV_BIT = 23;
  localparam int WISC_CA_WP_BIT = 22;
  localparam int WISC_CA_IP_LO  = 8;
  localparam int WISC_CA_EC_LO  = 2;
  // status: [22] boot vector, [2] error level, [1] exception level
  localparam int WISC_ST_BEV_BIT = 22;
  localparam int WISC_ST_ERL_BIT = 2;
  localparam int WISC_ST_EXL_BIT = 1;
  // shadow set control: [29:26] hss, [21:18] external_ctrl_shadow_set, [15:12] ess, [9:6] pss, [3:0] css
  localparam int WISC_SC_HSS_LO  = 26;
  localparam int WISC_SC_EIC_LO  = 18;
  localparam int WISC_SC_ESS_LO  = 12;
  localparam int WISC_SC_PSS_LO  = 6;
  localparam int WISC_SC_CSS_LO  = 0;
  // interrupt control: [9:5] vector spacing
  localparam int WISC_IC_VS_LO   = 5;
  // config three: [6] external controller present, [5] vectored irq supported
  localparam int WISC_C3_EXTERNAL_CTRL_PRESENT_BIT = 6;
  localparam int WISC_C3_VECTORED_IRQ_SUPPORTED_BIT = 5;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [4:0]  WISC_CODE_INT    = 5'h00;
  localparam logic [4:0]  WISC_CODE_WATCH  = 5'h17;
  localparam logic [11:0] WISC_VEC_GENERAL = 12'h180;
  localparam logic [11:0] WISC_VEC_IRQ     = 12'h200;
  localparam logic [3:0]  WISC_SETS_HIGH   = 4'hf;   // highest implemented set, up to 16 sets
  localparam logic [31:0] WISC_STATUS_RST  = 32'h0040_0004;
  localparam logic [31:0] WISC_ERR_DATA    = 32'h0000_0000;

  typedef logic [3:0] wisc_set_t;

  typedef enum logic [1:0] {
    WISC_KIND_OTHER,
    WISC_KIND_IRQ,
    WISC_KIND_ERL,
    WISC_KIND_DEBUG
  } wisc_kind_e;

  // pipeline report for one cycle
  typedef struct packed {
    logic        ref_valid;
    logic [31:0] ref_addr;
    logic        ref_fetch;
    logic        ref_load;
    logic        ref_store;
    logic        ref_cache_op;
    logic        ref_completes;
    logic        ref_other_exc;
    logic        exc_valid;
    wisc_kind_e  exc_kind;
    logic        exception_return_instr;
    logic        debug_return_instr;
    logic        debug_mode;
    logic [7:0]  irq_pending;
    logic [5:0]  irq_level;
    wisc_set_t   ext_set;
  } wisc_pipe_s;

  // entry announcement to the pipeline
  typedef struct packed {
    logic        take;
    logic        is_watch;
    logic [11:0] offset;
    logic [4:0]  code;
  } wisc_entry_s;

  typedef struct packed {
    logic [31:0] watch_lo;
    logic [11:3] watch_msk;
    logic        iv;
    logic        wp;
    logic [7:0]  ip;
    logic [4:0]  code;
    logic        boot_vector_select;
    logic        error_level_flag;
    logic        exception_level_flag;
    wisc_set_t   current_shadow_set;
    wisc_set_t   previous_shadow_set;
    wisc_set_t   exception_shadow_set;
    wisc_set_t   external_ctrl_shadow_set;
    logic [31:0] srs_map;
    logic [4:0]  vs;
    logic        external_ctrl_present;
    logic        vectored_irq_supported;
    wisc_entry_s entry;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } wisc_state_s;

endpackage
